// ### include/lsr_map.svh
// Command codes, field positions, timing and reset constants
`ifndef LSR_MAP_SVH
`define LSR_MAP_SVH
`define LSR_SLAVE_ADDR 7'h10
`define LSR_CMD_CONF 8'h00
`define LSR_CMD_THR_HI 8'h01
`define LSR_CMD_THR_LO 8'h02
`define LSR_CMD_PSM 8'h03
`define LSR_CMD_AMB 8'h04
`define LSR_CMD_WHITE 8'h05
`define LSR_CMD_FLAGS 8'h06
`define LSR_CONF_RST 16'h0001
`define LSR_PSM_RST 3'h0
`define LSR_CONF_SD 0
`define LSR_CONF_INT_EN 1
`define LSR_CONF_IT_HI 9
`define LSR_CONF_IT_LO 6
`define LSR_PS_EN_BIT 0
`define LSR_PS_MODE_HI 2
`define LSR_PS_MODE_LO 1
`define LSR_FLAG_RSVD 14'h0000
`define LSR_IT_25 4'hc
`define LSR_IT_50 4'h8
`define LSR_IT_100 4'h0
`define LSR_IT_200 4'h1
`define LSR_IT_400 4'h2
`define LSR_IT_800 4'h3
`define LSR_IT_25_MS 13'd25
`define LSR_IT_50_MS 13'd50
`define LSR_IT_100_MS 13'd100
`define LSR_IT_200_MS 13'd200
`define LSR_IT_400_MS 13'd400
`define LSR_IT_800_MS 13'd800
`define LSR_WAIT_M1_MS 13'd500
`define LSR_WAIT_M2_MS 13'd1000
`define LSR_WAIT_M3_MS 13'd2000
`define LSR_WAIT_M4_MS 13'd4000
`define LSR_CLK_KHZ 125000
`define LSR_BYTE_BITS 4'h8
`define LSR_LAST_BIT 4'h7
`endif

// ### include/lsr_pkg.sv
// Types shared by the light sensor register block
package lsr_pkg;
    typedef enum logic [3:0] {
        BS_IDLE, BS_ADDR, BS_ADDR_ACK, BS_CMD, BS_CMD_ACK,
        BS_WDATA, BS_WACK, BS_RDATA, BS_RACK
    } lsr_bus_st_t;
    typedef enum logic [1:0] {TM_IDLE, TM_INTEG, TM_WAIT} lsr_tim_st_t;
    typedef struct packed {
        logic shutdown;
        logic [3:0] it_sel;
        logic ps_en;
        logic [1:0] ps_mode;
    } lsr_tim_cfg_t;
    typedef struct packed {
        logic [15:0] ambient;
        logic [15:0] white;
    } lsr_sample_t;
endpackage

// ### rtl/lsr_timer.sv
// Measurement sequencer: integration followed by power-saving wait
`timescale 1ns/1ps
`include "lsr_map.svh"
module lsr_timer #(
    parameter int CYC_PER_MS = `LSR_CLK_KHZ
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire lsr_pkg::lsr_tim_cfg_t cfg,
    output logic integrating_r,
    output logic done_r
);
    import lsr_pkg::*;

    function automatic logic [12:0] integ_ms(input logic [3:0] sel);
        unique case (sel)
            `LSR_IT_25: integ_ms = `LSR_IT_25_MS;
            `LSR_IT_50: integ_ms = `LSR_IT_50_MS;
            `LSR_IT_100: integ_ms = `LSR_IT_100_MS;
            `LSR_IT_200: integ_ms = `LSR_IT_200_MS;
            `LSR_IT_400: integ_ms = `LSR_IT_400_MS;
            `LSR_IT_800: integ_ms = `LSR_IT_800_MS;
            default: integ_ms = `LSR_IT_100_MS;
        endcase
    endfunction

    function automatic logic [12:0] wait_ms(input logic [1:0] mode);
        unique case (mode)
            2'h0: wait_ms = `LSR_WAIT_M1_MS;
            2'h1: wait_ms = `LSR_WAIT_M2_MS;
            2'h2: wait_ms = `LSR_WAIT_M3_MS;
            2'h3: wait_ms = `LSR_WAIT_M4_MS;
        endcase
    endfunction

    lsr_tim_st_t st_r;
    logic [31:0] pre_r;
    logic [12:0] ms_r;
    logic ms_tick;
    logic integ_end;
    logic wait_end;

    assign ms_tick = (pre_r == 32'(CYC_PER_MS - 1));
    assign integ_end = ms_tick && (ms_r >= integ_ms(cfg.it_sel) - 13'd1);
    assign wait_end = ms_tick && (ms_r >= wait_ms(cfg.ps_mode) - 13'd1);

    // Millisecond prescaler
    always_ff @(posedge clk) begin
        if (sys_rst || st_r == TM_IDLE || ms_tick) begin
            pre_r <= 32'h0;
        end else begin
            pre_r <= pre_r + 32'h1;
        end
    end

    // Sequencer
    always_ff @(posedge clk) begin
        if (sys_rst || cfg.shutdown) begin
            st_r <= TM_IDLE;
            ms_r <= 13'h0;
        end else begin
            unique case (st_r)
                TM_IDLE: begin
                    st_r <= TM_INTEG;
                    ms_r <= 13'h0;
                end
                TM_INTEG: begin
                    if (integ_end) begin
                        ms_r <= 13'h0;
                        st_r <= cfg.ps_en ? TM_WAIT : TM_INTEG;
                    end else if (ms_tick) begin
                        ms_r <= ms_r + 13'h1;
                    end
                end
                TM_WAIT: begin
                    if (wait_end) begin
                        ms_r <= 13'h0;
                        st_r <= TM_INTEG;
                    end else if (ms_tick) begin
                        ms_r <= ms_r + 13'h1;
                    end
                end
            endcase
        end
    end

    // Status outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            done_r <= 1'b0;
            integrating_r <= 1'b0;
        end else begin
            done_r <= !cfg.shutdown && st_r == TM_INTEG && integ_end;
            integrating_r <= !cfg.shutdown && st_r == TM_INTEG;
        end
    end

    seq_next_a: assert property (@(posedge clk) disable iff (sys_rst)
        done_r |-> st_r == ($past(cfg.ps_en) ? TM_WAIT : TM_INTEG))
        else $error("wrong state after integration");
    integ_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        done_r |-> $past(ms_r) + 13'd1 >= integ_ms($past(cfg.it_sel)))
        else $error("integration ended early");
    wait_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == TM_WAIT && !cfg.shutdown && ms_tick
         && ms_r == wait_ms(cfg.ps_mode) - 13'd1)
        |=> st_r == TM_INTEG && ms_r == 13'h0)
        else $error("wait did not end on time");
    sd_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
        cfg.shutdown |=> st_r == TM_IDLE && !integrating_r && !done_r)
        else $error("measurement ran in shutdown");
endmodule

// ### rtl/lsr_top.sv
// Light sensor command registers behind a two-wire serial slave
// Notes on behaviour
// - Code 03h holds the power-saving word, written by the bus host only.
// - Bits 2:1 of code 03h choose power-saving mode 1 to 4.
// - Bit 0 of code 03h enables power saving with the chosen mode.
// - Code 04h reads the 16-bit ambient result, high byte in 15:8.
// - Code 05h reads the 16-bit white result, high byte in 15:8.
// - Bit 15 of code 06h flags a result below the low bound.
// - Bit 14 of code 06h flags above high bound; bits 13:0 reserved.
// - Power saving stretches refresh by mode and integration time.
// - Integration codes map to 25, 50, 100, 200, 400, 800 ms.
// - Slave answers at 7-bit address 0x10; last address bit selects read.
// - Shutdown keeps the last result readable; waking resumes measuring.
`timescale 1ns/1ps
`include "lsr_map.svh"
module lsr_top #(
    parameter int CYC_PER_MS = `LSR_CLK_KHZ
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire lsr_pkg::lsr_sample_t adc_i,
    output logic sda_o_r,
    output logic sda_oe_r,
    output logic integrating_r
);
    import lsr_pkg::*;

    logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    lsr_bus_st_t st_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r, tx_r, cmd_r, wlsb_r;
    logic [15:0] rd_hold_r, rd_word, wr_data;
    logic rw_r, byte_hi_r, mack_r;
    logic [15:0] conf_r, thr_hi_r, thr_lo_r, amb_r, white_r;
    logic [2:0] psm_r;
    logic flag_low_r, flag_high_r;
    logic wr_commit, flags_read, meas_done, set_low, set_high, sd_w;
    lsr_tim_cfg_t tcfg;

    // Pin synchronisers and edge history
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
            {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
        end else begin
            {scl_m_r, scl_s_r, scl_d_r} <= {scl_i, scl_m_r, scl_s_r};
            {sda_m_r, sda_s_r, sda_d_r} <= {sda_i, sda_m_r, sda_s_r};
        end
    end

    assign scl_rise = scl_s_r && !scl_d_r;
    assign scl_fall = !scl_s_r && scl_d_r;
    assign bus_start = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
    assign bus_stop = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
    assign wr_data = {sh_r, wlsb_r};
    assign wr_commit = st_r == BS_WDATA && scl_fall && cnt_r == `LSR_BYTE_BITS
        && byte_hi_r;
    assign flags_read = st_r == BS_RDATA && scl_fall && cnt_r == `LSR_LAST_BIT
        && byte_hi_r && cmd_r == `LSR_CMD_FLAGS;

    // Read word by command; write-only codes read as zero
    always_comb begin
        unique case (cmd_r)
            `LSR_CMD_AMB: rd_word = amb_r;
            `LSR_CMD_WHITE: rd_word = white_r;
            `LSR_CMD_FLAGS: rd_word = {flag_low_r, flag_high_r,
                `LSR_FLAG_RSVD};
            default: rd_word = 16'h0000;
        endcase
    end

    // Serial slave, low byte first on the wire
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= BS_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            cmd_r <= 8'h00;
            wlsb_r <= 8'h00;
            rd_hold_r <= 16'h0000;
            rw_r <= 1'b0;
            byte_hi_r <= 1'b0;
            mack_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (bus_start) begin
            st_r <= BS_ADDR;
            cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
        end else if (bus_stop) begin
            st_r <= BS_IDLE;
            sda_oe_r <= 1'b0;
        end else begin
            if (scl_rise && cnt_r != `LSR_BYTE_BITS && (st_r == BS_ADDR
                || st_r == BS_CMD || st_r == BS_WDATA)) begin
                sh_r <= {sh_r[6:0], sda_s_r};
                cnt_r <= cnt_r + 4'h1;
            end
            if (scl_rise && st_r == BS_RACK) begin
                mack_r <= !sda_s_r;
            end
            if (scl_fall) begin
                unique case (st_r)
                    BS_IDLE: begin
                    end
                    BS_ADDR: begin
                        if (cnt_r == `LSR_BYTE_BITS) begin
                            cnt_r <= 4'h0;
                            if (sh_r[7:1] == `LSR_SLAVE_ADDR) begin
                                st_r <= BS_ADDR_ACK;
                                sda_oe_r <= 1'b1;
                                rw_r <= sh_r[0];
                            end else begin
                                st_r <= BS_IDLE;
                            end
                        end
                    end
                    BS_CMD: begin
                        if (cnt_r == `LSR_BYTE_BITS) begin
                            cnt_r <= 4'h0;
                            cmd_r <= sh_r;
                            byte_hi_r <= 1'b0;
                            st_r <= BS_CMD_ACK;
                            sda_oe_r <= 1'b1;
                        end
                    end
                    BS_WDATA: begin
                        if (cnt_r == `LSR_BYTE_BITS) begin
                            cnt_r <= 4'h0;
                            if (!byte_hi_r) begin
                                wlsb_r <= sh_r;
                            end
                            byte_hi_r <= !byte_hi_r;
                            st_r <= BS_WACK;
                            sda_oe_r <= 1'b1;
                        end
                    end
                    BS_ADDR_ACK: begin
                        if (rw_r) begin
                            st_r <= BS_RDATA;
                            rd_hold_r <= rd_word;
                            tx_r <= rd_word[7:0];
                            sda_oe_r <= !rd_word[7];
                            byte_hi_r <= 1'b0;
                            cnt_r <= 4'h0;
                        end else begin
                            st_r <= BS_CMD;
                            sda_oe_r <= 1'b0;
                        end
                    end
                    BS_CMD_ACK, BS_WACK: begin
                        st_r <= BS_WDATA;
                        sda_oe_r <= 1'b0;
                    end
                    BS_RDATA: begin
                        if (cnt_r == `LSR_LAST_BIT) begin
                            cnt_r <= 4'h0;
                            sda_oe_r <= 1'b0;
                            st_r <= BS_RACK;
                        end else begin
                            cnt_r <= cnt_r + 4'h1;
                            tx_r <= {tx_r[6:0], 1'b0};
                            sda_oe_r <= !tx_r[6];
                        end
                    end
                    BS_RACK: begin
                        if (mack_r) begin
                            st_r <= BS_RDATA;
                            byte_hi_r <= !byte_hi_r;
                            tx_r <= byte_hi_r ? rd_hold_r[7:0]
                                : rd_hold_r[15:8];
                            sda_oe_r <= byte_hi_r ? !rd_hold_r[7]
                                : !rd_hold_r[15];
                        end else begin
                            st_r <= BS_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Open-drain data pin only ever pulls low
    always_ff @(posedge clk) begin
        sda_o_r <= 1'b0;
    end

    // Writable command registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            conf_r <= `LSR_CONF_RST;
            thr_hi_r <= 16'h0000;
            thr_lo_r <= 16'h0000;
            psm_r <= `LSR_PSM_RST;
        end else if (wr_commit) begin
            unique case (cmd_r)
                `LSR_CMD_CONF: conf_r <= wr_data;
                `LSR_CMD_THR_HI: thr_hi_r <= wr_data;
                `LSR_CMD_THR_LO: thr_lo_r <= wr_data;
                `LSR_CMD_PSM: psm_r <= wr_data[2:0];
                default: begin
                end
            endcase
        end
    end

    assign sd_w = conf_r[`LSR_CONF_SD];
    assign tcfg = '{shutdown: sd_w,
        it_sel: conf_r[`LSR_CONF_IT_HI:`LSR_CONF_IT_LO],
        ps_en: psm_r[`LSR_PS_EN_BIT],
        ps_mode: psm_r[`LSR_PS_MODE_HI:`LSR_PS_MODE_LO]};

    lsr_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .cfg(tcfg),
        .integrating_r(integrating_r),
        .done_r(meas_done)
    );

    // Results are only replaced at the end of an integration
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            amb_r <= 16'h0000;
            white_r <= 16'h0000;
        end else if (meas_done) begin
            amb_r <= adc_i.ambient;
            white_r <= adc_i.white;
        end
    end

    assign set_low = meas_done && conf_r[`LSR_CONF_INT_EN]
        && adc_i.ambient < thr_lo_r;
    assign set_high = meas_done && conf_r[`LSR_CONF_INT_EN]
        && adc_i.ambient > thr_hi_r;

    // Threshold flags clear on read of the status word; a set wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_low_r <= 1'b0;
            flag_high_r <= 1'b0;
        end else begin
            flag_low_r <= set_low || (flag_low_r && !flags_read);
            flag_high_r <= set_high || (flag_high_r && !flags_read);
        end
    end

    psm_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_commit && cmd_r == `LSR_CMD_PSM |=> psm_r == $past(wr_data[2:0]))
        else $error("power-saving word not stored");
    amb_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_r == BS_ADDR_ACK && scl_fall && rw_r && cmd_r == `LSR_CMD_AMB
        |=> rd_hold_r == $past(amb_r) && tx_r == $past(amb_r[7:0]))
        else $error("ambient word not presented");
    white_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_r == BS_ADDR_ACK && scl_fall && rw_r && cmd_r == `LSR_CMD_WHITE
        |=> rd_hold_r == $past(white_r))
        else $error("white word not presented");
    low_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        set_low |=> flag_low_r ##1 (flag_low_r || $past(flags_read)))
        else $error("low threshold flag lost");
    high_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        (meas_done && conf_r[`LSR_CONF_INT_EN] && adc_i.ambient > thr_hi_r)
        |=> flag_high_r)
        else $error("high threshold flag not set");
    addr_ack_a: assert property (@(posedge clk) disable iff (sys_rst)
        st_r == BS_ADDR && scl_fall && cnt_r == `LSR_BYTE_BITS
        && sh_r[7:1] == `LSR_SLAVE_ADDR |=> sda_oe_r && st_r == BS_ADDR_ACK)
        else $error("own address not acknowledged");
    sd_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        sd_w && $past(sd_w) |=> $stable(amb_r) && $stable(white_r))
        else $error("result changed in shutdown");
endmodule

// ### bench/lsr_host.sv
// Two-wire bus host model that drives the light sensor block
`timescale 1ns/1ps
`include "lsr_map.svh"
module lsr_host (
    input wire logic clk,
    input wire logic dev_pull,
    output logic scl_r,
    output logic sda
);
    logic pull_r = 1'b0;

    initial scl_r = 1'b1;

    // Pulled-up open-drain wire, low while either side pulls it
    assign sda = !dev_pull && !pull_r;

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Data changes mid-low, the device's bit is taken mid-high
    task automatic bit_io(input logic b, output logic r);
        step(3);
        pull_r <= !b;
        step(2);
        scl_r <= 1'b1;
        step(3);
        r = sda;
        step(2);
        scl_r <= 1'b0;
    endtask

    task automatic byte_io(input logic [7:0] d, input logic b9,
                           output logic [7:0] q, output logic r9);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(b9, r9);
    endtask

    // Plain or repeated start, clock left low
    task automatic start();
        step(1);
        if (scl_r === 1'b0) begin
            step(2);
            pull_r <= 1'b0;
            step(2);
            scl_r <= 1'b1;
            step(5);
        end
        pull_r <= 1'b1;
        step(5);
        scl_r <= 1'b0;
    endtask

    task automatic stop();
        step(3);
        pull_r <= 1'b1;
        step(2);
        scl_r <= 1'b1;
        step(5);
        pull_r <= 1'b0;
        step(10);
    endtask

    task automatic probe(input logic [7:0] a, output logic ok);
        logic [7:0] q;
        logic r;
        start();
        byte_io(a, 1'b1, q, r);
        ok = !r;
        stop();
    endtask

    task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d,
                           output logic ok);
        logic [7:0] q;
        logic r0, r1, r2, r3;
        start();
        byte_io({`LSR_SLAVE_ADDR, 1'b0}, 1'b1, q, r0);
        byte_io(cmd, 1'b1, q, r1);
        byte_io(d[7:0], 1'b1, q, r2);
        byte_io(d[15:8], 1'b1, q, r3);
        stop();
        ok = !(r0 | r1 | r2 | r3);
    endtask

    // Low byte acked by the host, high byte refused to end the read
    task automatic rd_word(input logic [7:0] cmd, output logic [15:0] v,
                           output logic ok);
        logic [7:0] q;
        logic r0, r1, r2, r3;
        start();
        byte_io({`LSR_SLAVE_ADDR, 1'b0}, 1'b1, q, r0);
        byte_io(cmd, 1'b1, q, r1);
        start();
        byte_io({`LSR_SLAVE_ADDR, 1'b1}, 1'b1, q, r2);
        byte_io(8'hff, 1'b0, v[7:0], r3);
        byte_io(8'hff, 1'b1, v[15:8], r3);
        stop();
        ok = !(r0 | r1 | r2);
    endtask
endmodule

// ### bench/lsr_top_bench.sv
// Self-checking bench for the light sensor register block
`timescale 1ns/1ps
`include "lsr_map.svh"
module lsr_top_bench;
    import lsr_pkg::*;
    localparam int CPM = 5;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    lsr_sample_t adc_i = {16'h1234, 16'h0abc};
    logic scl, sda, sda_o, sda_oe, busy;
    logic prev_busy = 1'b0;
    int n_errors = 0;
    int n_compared = 0;
    int run_n = 0;
    int hi_len = 0;
    int lo_len = 0;

    always #4 clk = ~clk;

    lsr_top #(.CYC_PER_MS(CPM)) dut (
        .clk(clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda),
        .adc_i(adc_i), .sda_o_r(sda_o), .sda_oe_r(sda_oe),
        .integrating_r(busy)
    );
    lsr_host host (.clk(clk), .dev_pull(sda_oe), .scl_r(scl), .sda(sda));

    // Lengths of the last high and low runs of the integration flag
    always @(negedge clk) begin
        if (busy !== prev_busy) begin
            if (prev_busy === 1'b1) hi_len = run_n;
            else lo_len = run_n;
            run_n = 1;
        end else begin
            run_n++;
        end
        prev_busy = busy;
    end

    task automatic wrap_up();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmp16(input logic [15:0] got, exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s %h/%h", $time, what, got, exp);
        end
    endtask

    // Cycle counts may be off by one millisecond tick
    task automatic cmp_near(input int got, input int exp, input string what);
        n_compared++;
        if (got < exp - CPM || got > exp + CPM) begin
            n_errors++;
            $display("wrong value at %0t: %s %0d/%0d", $time, what, got, exp);
        end
    endtask

    task automatic wait_lvl(input logic v);
        int n;
        n = 0;
        while (busy !== v) begin
            @(negedge clk);
            n++;
            if (n > 50000) begin
                n_errors++;
                $display("wrong value at %0t: no edge", $time);
                wrap_up();
            end
        end
        @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
        logic ok;
        host.wr_word(cmd, d, ok);
        cmp16({15'h0, ok}, 16'h0001, "write ack");
    endtask

    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp,
                      input string what);
        logic [15:0] v;
        logic ok;
        host.rd_word(cmd, v, ok);
        cmp16({15'h0, ok}, 16'h0001, "read ack");
        cmp16(v, exp, what);
    endtask

    task automatic t_address();
        logic ok;
        host.probe(8'h22, ok);
        cmp16({15'h0, ok}, 16'h0000, "foreign address");
        host.probe({`LSR_SLAVE_ADDR, 1'b0}, ok);
        cmp16({15'h0, ok}, 16'h0001, "own address");
    endtask

    task automatic t_results();
        wr(`LSR_CMD_PSM, 16'h0001);
        wr(`LSR_CMD_THR_HI, 16'h1000);
        wr(`LSR_CMD_THR_LO, 16'h0100);
        wr(`LSR_CMD_CONF, 16'h0302);
        wait_lvl(1'b0);
        cmp_near(hi_len, 25 * CPM, "integration");
        wr(`LSR_CMD_CONF, 16'h0303);
        @(posedge clk);
        adc_i <= {16'h0050, 16'h0321};
        repeat (300) @(negedge clk);
        cmp16({15'h0, busy}, 16'h0000, "stopped");
        rd(`LSR_CMD_AMB, 16'h1234, "ambient kept");
        rd(`LSR_CMD_WHITE, 16'h0abc, "white kept");
        rd(`LSR_CMD_FLAGS, 16'h4000, "high flag");
        rd(`LSR_CMD_FLAGS, 16'h0000, "flags cleared");
        rd(`LSR_CMD_PSM, 16'h0000, "write only");
        wr(`LSR_CMD_CONF, 16'h0302);
        wait_lvl(1'b0);
        rd(`LSR_CMD_AMB, 16'h0050, "ambient fresh");
        rd(`LSR_CMD_WHITE, 16'h0321, "white fresh");
        rd(`LSR_CMD_FLAGS, 16'h8000, "low flag");
        wr(`LSR_CMD_CONF, 16'h0001);
    endtask

    // Each row starts from shutdown so the first run is whole
    task automatic t_timing();
        logic [3:0] its[5] = '{4'h3, 4'h2, 4'h1, 4'h0, 4'h8};
        int ms[5] = '{800, 400, 200, 100, 50};
        int wt[4] = '{500, 1000, 2000, 4000};
        int n;
        for (int k = 0; k < 5; k++) begin
            wr(`LSR_CMD_PSM, {13'h0, k[1:0], k < 4});
            wr(`LSR_CMD_CONF, {6'h0, its[k], 6'h0});
            if (k < 4) begin
                wait_lvl(1'b0);
                cmp_near(hi_len, ms[k] * CPM, "integration");
                wait_lvl(1'b1);
                cmp_near(lo_len, wt[k] * CPM, "idle wait");
                if (k == 3) begin
                    cmp_near(hi_len + lo_len, 4100 * CPM, "refresh");
                end
            end else begin
                n = 0;
                repeat (200 * CPM) begin
                    @(negedge clk);
                    if (busy === 1'b1) n++;
                end
                cmp_near(n, 200 * CPM, "no idle wait");
            end
            wr(`LSR_CMD_CONF, 16'h0001);
        end
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        n_errors++;
        $display("wrong value at %0t: watchdog", $time);
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmp16({13'h0, sda_o, sda_oe, busy}, 16'h0000, "idle");
        t_address();
        t_results();
        t_timing();
        wrap_up();
    end
endmodule
